// file: logic/cpsc_device.sv
// Card power state control: device end between host link and socket.
// Assumes socket sense inputs are synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module cpsc_device
   import cpsc_pkg::*;
(
   input  wire logic              i_clk,              // 40 MHz clock
   input  wire logic              i_rst,              // Sync reset, high
   cpsc_if.dev                    lnk,                // Host side link
   input  wire logic              i_card_presence_in, // Socket switch
   input  wire logic              i_overtemp,         // Junction too hot
   input  wire logic              i_fault,            // Supply or line fault
   input  wire logic              i_supply_discharged,// Supply below 1 V
   input  wire logic              i_supply_final,     // Supply at level
   input  wire logic [CHAN_N-1:0] i_card_line,        // Card line levels
   output logic      [CHAN_N-1:0] o_card_line,        // Card line value
   output logic      [CHAN_N-1:0] o_card_line_oe,     // Card line drive
   output logic                   o_card_supply_on,   // Supply enabled
   output logic                   o_card_supply_high, // High level chosen
   output logic                   o_card_reset,       // Card reset pin
   output logic                   o_card_clock,       // Card clock pin
   output logic      [1:0]        o_state             // Current state
);
   cpsc_state_t state_r;
   cpsc_state_t state_nxt;
   logic        card_present;
   logic        fault_any;
   logic        expired;
   logic        powered;
   logic        usable;
   logic        card_detect_n_r;
   logic        ready_oe_r;
   logic        alarm_o_r;
   logic        alarm_oe_r;
   logic [CHAN_N-1:0] d_line_o_r;
   logic [CHAN_N-1:0] d_line_oe_r;
   logic [CHAN_N-1:0] card_line_r;
   logic [CHAN_N-1:0] card_line_oe_r;

   assign card_present = ~(i_card_presence_in ^ lnk.polarity_sel);
   // Losing the card counts as a fault
   assign fault_any    = i_fault | ~card_present;
   assign powered      = (state_r == CPSC_ACTIVE) || (state_r == CPSC_FAULT);
   // Ready low opens the channels
   assign usable       = ready_oe_r;

   cpsc_fault_timer u_timer (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_run     (state_r == CPSC_FAULT),
      .o_expired (expired)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         CPSC_IDLE: begin
            // Request held off until supply has bled down
            if (!lnk.power_request_n && i_supply_discharged) begin
               state_nxt = CPSC_ACTIVE;
            end
         end
         CPSC_ACTIVE: begin
            if (lnk.power_request_n) begin
               state_nxt = CPSC_IDLE;
            end else if (fault_any) begin
               state_nxt = CPSC_FAULT;
            end
         end
         CPSC_FAULT: begin
            if (lnk.power_request_n) begin
               state_nxt = CPSC_IDLE;
            end else if (!fault_any) begin
               state_nxt = CPSC_ACTIVE;
            end else if (expired) begin
               state_nxt = CPSC_ALARM;
            end
         end
         CPSC_ALARM: begin
            // Only exit; quick cycle clears alarm, idle still waits
            if (lnk.power_request_n && !i_overtemp) begin
               state_nxt = CPSC_IDLE;
            end
         end
         default: begin
            state_nxt = CPSC_IDLE;
         end
      endcase
      // Thermal shutdown overrides everything else
      if (i_overtemp) begin
         state_nxt = CPSC_ALARM;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_r <= CPSC_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Card supply, reset and clock; all low unless powered
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_card_supply_on   <= 1'b0;
         o_card_supply_high <= 1'b0;
         o_card_reset       <= 1'b0;
         o_card_clock       <= 1'b0;
      end else begin
         o_card_supply_on   <= powered;
         o_card_supply_high <= powered & lnk.supply_level_sel;
         o_card_reset       <= powered & lnk.card_reset_in;
         o_card_clock       <= powered & lnk.card_clock_in;
      end
   end

   // Host facing status pins
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         card_detect_n_r <= 1'b1;
         ready_oe_r      <= 1'b0;
         alarm_o_r       <= 1'b1;
         alarm_oe_r      <= 1'b0;
      end else begin
         card_detect_n_r <= i_card_presence_in ^ lnk.polarity_sel;
         // Ready doubles as the self-start interrupt
         ready_oe_r      <= powered & i_supply_final & card_present;
         // Released in idle, low in alarm, high when powered
         alarm_o_r       <= powered;
         alarm_oe_r      <= (state_r != CPSC_IDLE);
      end
   end

   // One direction per channel; first side to pull low owns it
   for (genvar i = 0; i < CHAN_N; i++) begin : g_chan
      cpsc_dir_t dir_r;
      cpsc_dir_t dir_nxt;

      always_comb begin
         dir_nxt = dir_r;
         if (!usable) begin
            dir_nxt = CPSC_DIR_NONE;
         end else begin
            case (dir_r)
               CPSC_DIR_NONE: begin
                  if (!lnk.host_line[i]) begin
                     dir_nxt = CPSC_DIR_H2C;
                  end else if (!i_card_line[i]) begin
                     dir_nxt = CPSC_DIR_C2H;
                  end
               end
               CPSC_DIR_H2C: begin
                  if (lnk.host_line[i]) begin
                     dir_nxt = CPSC_DIR_NONE;
                  end
               end
               CPSC_DIR_C2H: begin
                  if (i_card_line[i]) begin
                     dir_nxt = CPSC_DIR_NONE;
                  end
               end
               default: begin
                  dir_nxt = CPSC_DIR_NONE;
               end
            endcase
         end
      end

      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            dir_r             <= CPSC_DIR_NONE;
            card_line_r[i]    <= 1'b0;
            card_line_oe_r[i] <= 1'b1;
            d_line_o_r[i]     <= 1'b1;
            d_line_oe_r[i]    <= 1'b0;
         end else begin
            dir_r             <= dir_nxt;
            // Unpowered card lines held low
            card_line_r[i]    <= 1'b0;
            card_line_oe_r[i] <= ~powered | (dir_nxt == CPSC_DIR_H2C);
            // Host lines float unless card is talking
            d_line_o_r[i]     <= 1'b0;
            d_line_oe_r[i]    <= (dir_nxt == CPSC_DIR_C2H);
         end
      end
   end

   assign lnk.card_detect_n = card_detect_n_r;
   assign lnk.ready_o       = 1'b0;
   assign lnk.ready_oe      = ready_oe_r;
   assign lnk.alarm_o       = alarm_o_r;
   assign lnk.alarm_oe      = alarm_oe_r;
   assign lnk.d_line_o      = d_line_o_r;
   assign lnk.d_line_oe     = d_line_oe_r;
   assign o_card_line       = card_line_r;
   assign o_card_line_oe    = card_line_oe_r;
   assign o_state           = state_r;
endmodule
`default_nettype wire

// file: logic/cpsc_pkg.sv
// Shared constants for the card power state control pair.
// Assumes one 40 MHz clock on both ends, synchronous reset.
package cpsc_pkg;
   // Gray along idle, active, fault timeout, alarm
   typedef enum logic [1:0] {
      CPSC_IDLE   = 2'h0,
      CPSC_ACTIVE = 2'h1,
      CPSC_FAULT  = 2'h3,
      CPSC_ALARM  = 2'h2
   } cpsc_state_t;

   typedef enum logic [1:0] {
      CPSC_DIR_NONE = 2'h0,
      CPSC_DIR_H2C  = 2'h1,
      CPSC_DIR_C2H  = 2'h2
   } cpsc_dir_t;

   localparam int CHAN_N        = 3;
   localparam int CLK_PERIOD_NS = 25;
   localparam int FAULT_TIME_NS = 5000;
   localparam int FAULT_CYC     = FAULT_TIME_NS / CLK_PERIOD_NS;
   localparam int FAULT_CNT_W   = 8;
   localparam logic [FAULT_CNT_W-1:0] FAULT_CYC_V = FAULT_CNT_W'(FAULT_CYC);
   localparam int CCLK_DIV_W    = 2;

   localparam int AXI_AW = 8;
   localparam logic [AXI_AW-1:0] OFS_CTRL   = 8'h00;
   localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h04;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Control register fields
   localparam int CTRL_ON      = 0;
   localparam int CTRL_RESET   = 1;
   localparam int CTRL_CLK_RUN = 2;
   localparam int CTRL_LEVEL   = 3;
   localparam int CTRL_POL     = 4;
   localparam int CTRL_CLK_SRC = 5;
   localparam int CTRL_DRV_LO  = 8;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   // Status register fields
   localparam int ST_READY = 0;
   localparam int ST_ALARM = 1;
   localparam int ST_CARD  = 2;
   localparam int ST_PWR_N = 3;
   localparam int ST_LINE  = 4;
endpackage

// file: logic/cpsc_if.sv
// Link between host controller and card power device.
// Models pull-ups on the open-drain lines; no clocking block.
`timescale 1ns/1ps
`default_nettype none
interface cpsc_if;
   import cpsc_pkg::*;
   logic              power_request_n;
   logic              card_reset_in;
   logic              card_clock_in;
   logic              supply_level_sel;
   logic              polarity_sel;
   logic              card_detect_n;
   logic              ready_o;
   logic              ready_oe;
   logic              alarm_o;
   logic              alarm_oe;
   logic [CHAN_N-1:0] h_line_o;
   logic [CHAN_N-1:0] h_line_oe;
   logic [CHAN_N-1:0] d_line_o;
   logic [CHAN_N-1:0] d_line_oe;
   logic [CHAN_N-1:0] host_line;
   logic              ready_lvl;
   logic              alarm_lvl;

   // Pulled high unless some driver pulls low
   assign host_line = ~(h_line_oe & ~h_line_o) & ~(d_line_oe & ~d_line_o);
   assign ready_lvl = ready_oe ? ready_o : 1'b1;
   assign alarm_lvl = alarm_oe ? alarm_o : 1'b1;

   modport dev (
      input  power_request_n, card_reset_in, card_clock_in,
      input  supply_level_sel, polarity_sel, host_line,
      output card_detect_n, ready_o, ready_oe, alarm_o, alarm_oe,
      output d_line_o, d_line_oe
   );
   modport host (
      output power_request_n, card_reset_in, card_clock_in,
      output supply_level_sel, polarity_sel, h_line_o, h_line_oe,
      input  card_detect_n, ready_lvl, alarm_lvl, host_line
   );
endinterface
`default_nettype wire

// file: logic/cpsc_fault_timer.sv
// Fault duration counter for the device end.
// Assumes i_run stays high for the whole fault timeout stay.
`timescale 1ns/1ps
`default_nettype none
module cpsc_fault_timer
   import cpsc_pkg::*;
(
   input  wire logic i_clk,      // 40 MHz clock
   input  wire logic i_rst,      // Sync reset, high
   input  wire logic i_run,      // Fault being timed
   output logic      o_expired   // Fault lasted past limit
);
   logic [FAULT_CNT_W-1:0] count_r;

   // Dropping i_run clears count, so each onset starts at zero
   always_ff @(posedge i_clk) begin
      if (i_rst || !i_run) begin
         count_r <= '0;
      end else if (count_r != FAULT_CYC_V) begin
         count_r <= count_r + 1'b1;
      end
   end

   assign o_expired = (count_r == FAULT_CYC_V);
endmodule
`default_nettype wire

// file: logic/cpsc_host.sv
// Host controller end: AXI4-Lite registers drive the device link.
// Assumes the device end shares i_clk.
`timescale 1ns/1ps
`default_nettype none
module cpsc_host
   import cpsc_pkg::*;
(
   input  wire logic              i_clk,           // 40 MHz clock
   input  wire logic              i_rst,           // Sync reset, high
   input  wire logic [AXI_AW-1:0] i_awaddr,        // Write address
   input  wire logic              i_awvalid,       // Write addr valid
   output logic                   o_awready,       // Write addr ready
   input  wire logic [31:0]       i_wdata,         // Write data
   input  wire logic [3:0]        i_wstrb,         // Byte enables
   input  wire logic              i_wvalid,        // Write data valid
   output logic                   o_wready,        // Write data ready
   output logic [1:0]             o_bresp,         // Write response
   output logic                   o_bvalid,        // Response valid
   input  wire logic              i_bready,        // Response ready
   input  wire logic [AXI_AW-1:0] i_araddr,        // Read address
   input  wire logic              i_arvalid,       // Read addr valid
   output logic                   o_arready,       // Read addr ready
   output logic [31:0]            o_rdata,         // Read data
   output logic [1:0]             o_rresp,         // Read response
   output logic                   o_rvalid,        // Read data valid
   input  wire logic              i_rready,        // Read data ready
   output logic                   o_clock_source_sel, // Clock mux select
   cpsc_if.host                   lnk              // Device link
);
   logic [AXI_AW-1:0]    awaddr_r;
   logic [31:0]          wdata_r;
   logic [3:0]           wstrb_r;
   logic [15:0]          ctrl_r;
   logic                 live_r;
   logic                 pwr_n_r;
   logic                 rin_r;
   logic                 cin_r;
   logic [CCLK_DIV_W-1:0] div_r;
   logic [CHAN_N-1:0]    h_oe_r;
   logic                 wr_go;
   logic                 clk_run;
   logic [31:0]          status;

   assign wr_go   = ~o_awready & ~o_wready & ~o_bvalid;
   assign clk_run = live_r & ctrl_r[CTRL_CLK_RUN];
   assign status  = {25'h000_0000, lnk.host_line, lnk.power_request_n,
                     ~lnk.card_detect_n, ~lnk.alarm_lvl, ~lnk.ready_lvl};

   // Write channel: address and data taken in either order
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_awready <= 1'b1;
         o_wready  <= 1'b1;
         o_bvalid  <= 1'b0;
         o_bresp   <= RESP_OKAY;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
      end else begin
         if (i_awvalid && o_awready) begin
            awaddr_r  <= i_awaddr;
            o_awready <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            wdata_r  <= i_wdata;
            wstrb_r  <= i_wstrb;
            o_wready <= 1'b0;
         end
         if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp  <= (awaddr_r == OFS_CTRL) ? RESP_OKAY : RESP_SLVERR;
         end
         if (o_bvalid && i_bready) begin
            o_bvalid  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_go && awaddr_r == OFS_CTRL) begin
         for (int b = 0; b < 2; b++) begin
            if (wstrb_r[b]) begin
               ctrl_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
            end
         end
      end
   end

   // Read channel
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= '0;
         o_rresp   <= RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rresp   <= RESP_OKAY;
         if (i_araddr == OFS_CTRL) begin
            o_rdata <= {16'h0000, ctrl_r};
         end else if (i_araddr == OFS_STATUS) begin
            o_rdata <= status;
         end else begin
            o_rdata <= '0;
            o_rresp <= RESP_SLVERR;
         end
      end else if (o_rvalid && i_rready) begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
      end
   end

   // Power off: drop live_r first; request rises and lines release together a cycle later
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pwr_n_r <= 1'b1;
         live_r  <= 1'b0;
      end else begin
         live_r  <= ctrl_r[CTRL_ON] & ~pwr_n_r;
         pwr_n_r <= ctrl_r[CTRL_ON] ? 1'b0 : (live_r ? pwr_n_r : 1'b1);
      end
   end

   // Card clock stops when not wanted, saving card power
   always_ff @(posedge i_clk) begin
      if (i_rst || !clk_run) begin
         div_r <= '0;
         cin_r <= 1'b0;
      end else begin
         div_r <= div_r + 1'b1;
         if (&div_r) begin
            cin_r <= ~cin_r;
         end
      end
   end

   // Source select moves only while clock is stopped
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_clock_source_sel <= 1'b0;
      end else if (!clk_run && !cin_r) begin
         o_clock_source_sel <= ctrl_r[CTRL_CLK_SRC];
      end
   end

   // Lines driven only once ready is seen low
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rin_r  <= 1'b0;
         h_oe_r <= '0;
      end else begin
         rin_r  <= live_r & ctrl_r[CTRL_RESET];
         h_oe_r <= {CHAN_N{live_r & ~lnk.ready_lvl}} & ctrl_r[CTRL_DRV_LO +: CHAN_N];
      end
   end

   assign lnk.power_request_n  = pwr_n_r;
   assign lnk.card_reset_in    = rin_r;
   assign lnk.card_clock_in    = cin_r;
   assign lnk.supply_level_sel = ctrl_r[CTRL_LEVEL];
   assign lnk.polarity_sel     = ctrl_r[CTRL_POL];
   assign lnk.h_line_o         = '0;
   assign lnk.h_line_oe        = h_oe_r;
endmodule
`default_nettype wire

// file: testbench/cpsc_asserts.sv
// Checker on the link between the host end and the device end.
// Assumes one clock and a synchronous active-high reset for both ends.
`timescale 1ns/1ps
`default_nettype none
module cpsc_asserts
   import cpsc_pkg::*;
(
   input  wire logic              i_clk,           // 40 MHz clock
   input  wire logic              i_rst,           // Sync reset, high
   input  wire logic              power_request_n, // Low asks for power
   input  wire logic              card_reset_in,   // Host card reset
   input  wire logic              card_clock_in,   // Host card clock
   input  wire logic              ready_o,         // Ready value
   input  wire logic              ready_oe,        // Ready drive
   input  wire logic              alarm_o,         // Alarm value
   input  wire logic              alarm_oe,        // Alarm drive
   input  wire logic [CHAN_N-1:0] h_line_oe,       // Host line drive
   input  wire logic [CHAN_N-1:0] d_line_oe        // Device line drive
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   logic alarm_lo;
   assign alarm_lo = alarm_oe & ~alarm_o;

   // Four cycles: state, ready and line drive each lag one register
   sequence s_off;
      power_request_n [*4];
   endsequence
   sequence s_alarm_held;
      (alarm_lo && !power_request_n) [*3];
   endsequence

   rdy_low_a: assert property (ready_oe |-> !ready_o && !$past(power_request_n, 2))
      else $error("ready driven high");
   rdy_alarm_a: assert property (ready_oe |-> alarm_oe && alarm_o)
      else $error("ready without alarm held high");
   off_ready_a: assert property (s_off |-> !ready_oe)
      else $error("ready still driven after power off");
   idle_lines_a: assert property (s_off |-> d_line_oe == '0)
      else $error("host lines driven while off");
   host_order_a: assert property (power_request_n |-> !card_reset_in && !card_clock_in && h_line_oe == '0)
      else $error("host lines live while power request high");
   alarm_stay_a: assert property (s_alarm_held |=> alarm_lo)
      else $error("alarm left with request low");
   alarm_idle_a: assert property (alarm_lo |-> !ready_oe)
      else $error("ready driven in alarm");
   chan_ready_a: assert property (|d_line_oe |-> ready_oe || $past(ready_oe))
      else $error("host line driven before ready");
endmodule
`default_nettype wire

// file: testbench/card_power_state_control_tb_top.sv
// Bench joining host and device ends over the link, driven through AXI4-Lite.
// Assumes the card socket sense inputs are modelled here, card lines pulled up.
`timescale 1ns/1ps
`default_nettype none
module card_power_state_control_tb_top;
   import cpsc_pkg::*;
   logic              i_clk = 1'b0;
   logic              i_rst = 1'b1;
   logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
   logic [31:0]       wdata = '0, rd_val, r_data;
   logic [3:0]        wstrb = 4'h0;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic              aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, sup_on, sup_hi, c_rst, c_clk, clk_sel;
   logic [1:0]        b_resp, r_resp, st;
   logic              card_presence_in = 1'b0, overtemp = 1'b0, fault = 1'b0, dischg = 1'b1, final_lv = 1'b0;
   logic [CHAN_N-1:0] card_pull = '0, card_line, cl_o, cl_oe;
   int                seed = 32'h2a28_cfc5, err_total = 0, samples_checked = 0, cyc = 0;

   always #12.5 i_clk = ~i_clk;
   // Pull-up on card lines; either side may pull low
   assign card_line = ~cl_oe & ~card_pull;

   cpsc_if lnk ();
   cpsc_host i_cpsc_host (.i_clk(i_clk), .i_rst(i_rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(aw_rdy), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(w_rdy),
      .o_bresp(b_resp), .o_bvalid(b_vld), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(ar_rdy), .o_rdata(r_data), .o_rresp(r_resp), .o_rvalid(r_vld), .i_rready(rready),
      .o_clock_source_sel(clk_sel), .lnk(lnk));
   cpsc_device i_cpsc_device (.i_clk(i_clk), .i_rst(i_rst), .lnk(lnk), .i_card_presence_in(card_presence_in),
      .i_overtemp(overtemp), .i_fault(fault), .i_supply_discharged(dischg), .i_supply_final(final_lv),
      .i_card_line(card_line), .o_card_line(cl_o), .o_card_line_oe(cl_oe), .o_card_supply_on(sup_on),
      .o_card_supply_high(sup_hi), .o_card_reset(c_rst), .o_card_clock(c_clk), .o_state(st));
   cpsc_asserts i_cpsc_asserts (.i_clk(i_clk), .i_rst(i_rst), .power_request_n(lnk.power_request_n),
      .card_reset_in(lnk.card_reset_in), .card_clock_in(lnk.card_clock_in), .ready_o(lnk.ready_o),
      .ready_oe(lnk.ready_oe), .alarm_o(lnk.alarm_o), .alarm_oe(lnk.alarm_oe), .h_line_oe(lnk.h_line_oe),
      .d_line_oe(lnk.d_line_oe));

   task automatic end_sim();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge i_clk);
   endtask
   task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= {2'($random(seed)), 2'b11};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (aw_rdy) awvalid <= 1'b0;
         if (w_rdy) wvalid <= 1'b0;
         n++;
      end while (b_vld !== 1'b1 && n < 64);
      bready <= 1'b0;
      chk(b_vld === 1'b1 && b_resp === er, "write response");
      @(posedge i_clk);
   endtask
   task automatic axi_rd(input logic [AXI_AW-1:0] a, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (ar_rdy) arvalid <= 1'b0;
         n++;
      end while (r_vld !== 1'b1 && n < 64);
      rready <= 1'b0;
      rd_val = r_data;
      chk(r_vld === 1'b1 && r_resp === er, "read response");
      @(posedge i_clk);
   endtask
   task automatic wait_st(input logic [1:0] s, input int lim, input string msg);
      int n;
      n = 0;
      while (st !== s && n < lim) begin
         @(posedge i_clk);
         n++;
      end
      chk(st === s, msg);
   endtask
   function automatic logic [31:0] ctrl_w(input logic on, rst, run, lvl, pol, input logic [2:0] drv);
      return {21'h0, drv, 3'h0, pol, lvl, run, rst, on};
   endfunction
   function automatic logic exp_det(input logic p, input logic q);
      return p ^ q;
   endfunction

   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end

   initial begin
      logic        lvl, prev;
      logic [2:0]  drv, c;
      logic [31:0] on_w;
      int          edges, len;
      tick(16);
      i_rst <= 1'b0;
      tick(1);
      axi_rd(OFS_CTRL, RESP_OKAY);
      chk(rd_val === 32'h0000_0000, "ctrl reset value");
      axi_rd(8'h0c, RESP_SLVERR);
      chk(rd_val === 32'h0000_0000, "unmapped read data");
      axi_wr(8'h08, 32'hffff_ffff, RESP_SLVERR);
      axi_wr(OFS_STATUS, 32'hffff_ffff, RESP_SLVERR);
      for (int k = 0; k < 4; k++) begin
         card_presence_in <= k[1];
         axi_wr(OFS_CTRL, ctrl_w(1'b0, 1'b0, 1'b0, 1'b0, k[0], 3'h0) | {26'h0, k[0], 5'h0}, RESP_OKAY);
         tick(3);
         chk(lnk.card_detect_n === exp_det(k[1], k[0]), "card detect");
         chk(clk_sel === k[0], "clock select while stopped");
         chk(cl_o === 3'h0, "card line value");
         chk(lnk.ready_lvl === 1'b1 && lnk.alarm_lvl === 1'b1 && lnk.d_line_oe === 3'h0, "idle release");
         chk(sup_on === 1'b0 && c_rst === 1'b0 && c_clk === 1'b0 && cl_oe === 3'h7, "idle low");
         axi_rd(OFS_STATUS, RESP_OKAY);
         chk(rd_val[3:0] === {1'b1, ~exp_det(k[1], k[0]), 2'b00}, "status idle bits");
      end
      lvl = 1'($random(seed));
      drv = 3'($random(seed)) | 3'h1;
      on_w = ctrl_w(1'b1, 1'b1, 1'b1, lvl, 1'b0, 3'h0);
      card_presence_in <= 1'b0;
      dischg <= 1'b0;
      axi_wr(OFS_CTRL, ctrl_w(1'b1, 1'b0, 1'b0, lvl, 1'b0, 3'h0), RESP_OKAY);
      tick(20);
      chk(st === CPSC_IDLE, "activation held off");
      dischg <= 1'b1;
      wait_st(CPSC_ACTIVE, 10, "activation");
      final_lv <= 1'b1;
      tick(4);
      chk(sup_on === 1'b1 && sup_hi === lvl, "supply level");
      chk(lnk.ready_lvl === 1'b0 && lnk.alarm_lvl === 1'b1, "ready after final level");
      // Source select asked for while the clock runs must wait
      axi_wr(OFS_CTRL, on_w | {21'h0, drv, 8'h20}, RESP_OKAY);
      edges = 0;
      prev = c_clk;
      for (int k = 0; k < 40; k++) begin
         @(posedge i_clk);
         if (c_clk !== prev) edges++;
         prev = c_clk;
      end
      chk(c_rst === 1'b1 && edges >= 8, "reset and clock pass");
      chk(cl_oe === drv, "host to card lines");
      chk(clk_sel === 1'b0, "select held while clock runs");
      axi_wr(OFS_CTRL, on_w, RESP_OKAY);
      tick(6);
      c = 3'($random(seed)) | 3'h2;
      card_pull <= c;
      tick(6);
      chk(lnk.host_line === ~c, "card to host lines");
      axi_rd(OFS_STATUS, RESP_OKAY);
      chk(rd_val[6:0] === {~c, 4'b0101}, "status active bits");
      card_pull <= 3'h0;
      // Two near-limit faults in a row only pass if timing restarts each onset
      for (int k = 0; k < 2; k++) begin
         len = 150 + ($unsigned($random(seed)) % 31);
         tick(4);
         fault <= 1'b1;
         tick(len);
         chk(st === CPSC_FAULT, "fault timing");
         fault <= 1'b0;
         wait_st(CPSC_ACTIVE, 5, "short fault recovers");
      end
      fault <= 1'b1;
      tick(240);
      chk(st === CPSC_ALARM && sup_on === 1'b0 && lnk.alarm_lvl === 1'b0, "long fault alarms");
      fault <= 1'b0;
      tick(30);
      chk(st === CPSC_ALARM && lnk.ready_lvl === 1'b1, "alarm held");
      dischg <= 1'b0;
      axi_wr(OFS_CTRL, on_w & ~32'h0000_0001, RESP_OKAY);
      wait_st(CPSC_IDLE, 10, "alarm to idle");
      axi_wr(OFS_CTRL, on_w, RESP_OKAY);
      tick(10);
      chk(st === CPSC_IDLE && lnk.alarm_lvl === 1'b1, "alarm cleared, no restart");
      dischg <= 1'b1;
      wait_st(CPSC_ACTIVE, 10, "restart after discharge");
      tick(300);
      chk(sup_on === 1'b1, "powered while card present");
      card_presence_in <= 1'b1;
      tick(4);
      chk(st === CPSC_FAULT, "removal seen as fault");
      tick(240);
      chk(st === CPSC_ALARM && sup_on === 1'b0, "removal deactivates");
      card_presence_in <= 1'b0;
      axi_wr(OFS_CTRL, on_w & ~32'h0000_0001, RESP_OKAY);
      wait_st(CPSC_IDLE, 10, "back to idle");
      axi_wr(OFS_CTRL, on_w, RESP_OKAY);
      wait_st(CPSC_ACTIVE, 10, "active again");
      axi_wr(OFS_CTRL, on_w & ~32'h0000_0001, RESP_OKAY);
      wait_st(CPSC_IDLE, 10, "power off");
      tick(3);
      chk(sup_on === 1'b0 && lnk.ready_lvl === 1'b1, "off deactivates");
      overtemp <= 1'b1;
      wait_st(CPSC_ALARM, 4, "overtemperature");
      tick(2);
      chk(lnk.alarm_lvl === 1'b0 && sup_on === 1'b0, "overtemp alarm pin");
      overtemp <= 1'b0;
      wait_st(CPSC_IDLE, 10, "overtemp cleared");
      end_sim();
   end
endmodule
`default_nettype wire
